// *** design/irq_cause.sv ***
// interrupt cause register with clear-on-read, enable register and interrupt pin
// assumes event pulses and mode come from logic on clk; analog and pin levels are async
//
// Summary of operation
// RQ1: reading the cause register, or any reset, clears its flags.
// RQ2: events arriving during a read survive the clear and show next read.
// RQ3: after each read the interrupt pin is held high for a fixed time.
// RQ4: in normal and flash modes non-urgent causes signal once per watchdog period.
// RQ5: clock-count and battery failures signal at once; host reacts immediately.
// RQ6: host reads causes with address 01 and feedback select bit 13 set.
// RQ7: read-only bit 12 low also writes frame low bits into the enable register.
// RQ8: bit 11 sets on watchdog overflow in standby.
// RQ9: bit 10 sets when temperature crosses the warning limit either way.
// RQ10: bit 9 sets when ground shift crosses its limit either way.
// RQ11: bit 8 sets on a wrong clock count; startup and restart reset instead.
// RQ12: frames with a clock count other than 16 write no register and clear no flag.
// RQ13: bit 7 sets on a falling edge of the battery monitor.
// RQ14: bit 6 sets on a short at either supply output.
// RQ15: bit 5 sets when the transceiver failure status changes.
// RQ16: bit 4 sets when the lin transceiver failure status changes.
// RQ17: bit 3 sets on a falling edge at the wake pin.
// RQ18: host writes reserved bit 2 as zero.
// RQ19: bit 1 sets on a bus wake-up when that interrupt is enabled.
// RQ20: bit 0 sets on a lin wake-up when that interrupt is enabled.
// RQ21: bus wake with its interrupt disabled requests a reset instead.
// RQ22: a flag raises the interrupt only when its enable bit is set.
// RQ23: interrupt pin is low while an enabled flag is pending and allowed.
// RQ24: a read frame shifts out the causes captured at frame start, msb first.
`timescale 1ns/100ps
module irq_cause
  import irq_cause_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic spi_sck,
  input wire logic spi_csn,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire mode_t mode,
  input wire logic wdt_overflow,
  input wire logic wdt_period_tick,
  input wire logic reset_event,
  input wire logic overtemp_warn_in,
  input wire logic ground_shift_in,
  input wire logic battery_monitor_in,
  input wire logic wake_pin_in,
  input wire logic can_fail_status,
  input wire logic lin_fail_status,
  input wire logic supply_short_det,
  input wire logic can_bus_event,
  input wire logic lin_bus_event,
  output logic irq_out_n,
  output logic reset_req,
  output logic [15:0] irq_enable
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  spi_frame_if fr ();
  logic [LVL_N-1:0] lvl;
  logic [LVL_N-1:0] lvl_rise;
  logic [LVL_N-1:0] lvl_fall;
  logic [15:0] cause;
  logic [15:0] ev;
  logic [15:0] set_vec;
  logic [15:0] pending;
  logic [HOLD_W-1:0] hold;
  logic nonurg_ok;
  logic paced;
  logic early_mode;
  logic addr_hit;
  logic read_hit;
  logic write_hit;
  logic spi_bad;
  logic irq_active;
  logic next_reset_req;

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  spi_frame u_spi (
    .clk(clk),
    .sys_rst(sys_rst),
    .spi_sck(spi_sck),
    .spi_csn(spi_csn),
    .spi_mosi(spi_mosi),
    .fr(fr.link)
  );

  sync_edge #(.W(LVL_N), .INIT(LVL_INIT)) u_lvl (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({lin_fail_status, can_fail_status, wake_pin_in,
               battery_monitor_in, ground_shift_in, overtemp_warn_in}),
    .level(lvl),
    .rise(lvl_rise),
    .fall(lvl_fall)
  );

  // ----------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------
  // the shifter loads the live register at frame start and keeps that copy
  assign fr.tx = cause; // RQ24
  assign addr_hit = fr.ok && (fr.rx[ADDR_HI:ADDR_LO] == ADDR_IRQ);
  // only complete 16-clock frames reach any register
  assign read_hit = fr.done && addr_hit && fr.rx[FEEDBACK_BIT]; // RQ6 RQ12
  assign write_hit = fr.done && addr_hit && !fr.rx[READ_ONLY_BIT]; // RQ7 RQ12
  assign spi_bad = fr.done && !fr.ok;
  assign paced = (mode == MODE_NORMAL) || (mode == MODE_FLASH);
  assign early_mode = (mode == MODE_STARTUP) || (mode == MODE_RESTART);

  // ----------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------
  always_comb begin
    ev = '0;
    ev[WDT_BIT] = wdt_overflow && (mode == MODE_STANDBY); // RQ8
    ev[OTEMP_BIT] = lvl_rise[LVL_OTEMP] || lvl_fall[LVL_OTEMP]; // RQ9
    ev[GND_BIT] = lvl_rise[LVL_GND] || lvl_fall[LVL_GND]; // RQ10
    ev[SPI_BIT] = spi_bad && !early_mode; // RQ11
    ev[BAT_BIT] = lvl_fall[LVL_BAT]; // RQ13
    ev[SHORT_BIT] = supply_short_det; // RQ14
    ev[CANF_BIT] = lvl_rise[LVL_CANF] || lvl_fall[LVL_CANF]; // RQ15
    ev[LINF_BIT] = lvl_rise[LVL_LINF] || lvl_fall[LVL_LINF]; // RQ16
    ev[WAKE_BIT] = lvl_fall[LVL_WAKE]; // RQ17
    ev[CANW_BIT] = can_bus_event; // RQ19
    ev[LINW_BIT] = lin_bus_event; // RQ20
  end

  // disabled sources set no cause flag; reserved bit 2 never sets
  assign set_vec = ev & irq_enable & FLAG_MASK; // RQ22

  // ----------------------------------------------------------------
  // reset requests replacing interrupts
  // ----------------------------------------------------------------
  always_comb begin
    next_reset_req = 1'b0;
    if (spi_bad && early_mode && irq_enable[SPI_BIT]) begin
      next_reset_req = 1'b1; // RQ11
    end
    if (can_bus_event && !irq_enable[CANW_BIT]) begin
      next_reset_req = 1'b1; // RQ21
    end
    if (lin_bus_event && !irq_enable[LINW_BIT]) begin
      next_reset_req = 1'b1;
    end
    if (lvl_fall[LVL_WAKE] && !irq_enable[WAKE_BIT] && (mode == MODE_STANDBY)) begin
      next_reset_req = 1'b1;
    end
    if (wdt_overflow && !irq_enable[WDT_BIT] && (mode == MODE_STANDBY)) begin
      next_reset_req = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reset_req <= 1'b0;
    end else begin
      reset_req <= next_reset_req;
    end
  end

  // ----------------------------------------------------------------
  // enable register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_enable <= ENABLE_RESET;
    end else if (write_hit) begin
      irq_enable <= fr.rx & ENABLE_MASK; // RQ7
    end
  end

  // ----------------------------------------------------------------
  // cause register
  // ----------------------------------------------------------------
  // only bits that were shifted out are cleared, and a new set wins
  always_ff @(posedge clk) begin
    if (sys_rst || reset_event) begin
      cause <= CAUSE_RESET; // RQ1
    end else if (read_hit) begin
      cause <= ((cause & ~fr.sent) | set_vec) & FLAG_MASK; // RQ1 RQ2
    end else begin
      cause <= (cause | set_vec) & FLAG_MASK;
    end
  end

  assign pending = cause & irq_enable; // RQ22

  // ----------------------------------------------------------------
  // interrupt pacing and pin
  // ----------------------------------------------------------------
  // after a read in normal and flash modes, non-urgent causes wait for the next watchdog period start
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nonurg_ok <= 1'b0;
    end else if (read_hit) begin
      nonurg_ok <= 1'b0; // RQ4
    end else if (!paced || wdt_period_tick) begin
      nonurg_ok <= 1'b1; // RQ4
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold <= '0;
    end else if (read_hit) begin
      hold <= IRQ_HIGH_CYCLES; // RQ3
    end else if (hold != '0) begin
      hold <= hold - HOLD_W'(1);
    end
  end

  // urgent causes bypass the pacing
  assign irq_active = (|(pending & URGENT_MASK)) ||
                      ((|(pending & ~URGENT_MASK)) && nonurg_ok); // RQ5 RQ4

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= !(irq_active && (hold == '0) && !read_hit); // RQ23 RQ3
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso <= fr.miso; // RQ24
      spi_miso_oe <= fr.miso_oe;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  read_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ1
    read_hit && !reset_event |=> ((cause & $past(fr.sent)) ==
                                  ($past(set_vec) & $past(fr.sent))))
    else $error("read did not clear reported causes");

  reset_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ1
    reset_event |=> (cause == CAUSE_RESET))
    else $error("reset event did not clear causes");

  event_keep_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ2
    (|set_vec) && !reset_event |=> ((cause & $past(set_vec)) == $past(set_vec)))
    else $error("event lost");

  pin_high_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ3
    read_hit |=> irq_out_n [*8])
    else $error("interrupt pin not held high after read");

  pace_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ4
    !nonurg_ok && !(|(pending & URGENT_MASK)) |=> irq_out_n)
    else $error("non-urgent cause signalled outside its period");

  urgent_fast_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ5
    (|(pending & URGENT_MASK)) && (hold == '0) && !read_hit |=> !irq_out_n)
    else $error("urgent cause not signalled at once");

  bad_frame_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ12
    spi_bad && !reset_event |=> $stable(irq_enable) &&
                                ((cause & $past(cause)) == $past(cause)))
    else $error("bad frame changed a register");

  spi_flag_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ11
    spi_bad && irq_enable[SPI_BIT] && !early_mode && !reset_event |=> cause[SPI_BIT])
    else $error("clock-count flag not set");

  wake_edge_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ17
    lvl_fall[LVL_WAKE] && irq_enable[WAKE_BIT] && !reset_event |=> cause[WAKE_BIT])
    else $error("wake flag not set");

  bus_reset_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ21
    can_bus_event && !irq_enable[CANW_BIT] |=> reset_req)
    else $error("bus wake without enable gave no reset request");

  enable_write_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ7
    write_hit |=> (irq_enable == ($past(fr.rx) & ENABLE_MASK)))
    else $error("enable register not written");

  read_seen_c: cover property (@(posedge clk) disable iff (sys_rst) read_hit);
  bad_frame_c: cover property (@(posedge clk) disable iff (sys_rst) spi_bad);
  irq_fall_c: cover property (@(posedge clk) disable iff (sys_rst) $fell(irq_out_n));
  set_in_read_c: cover property (@(posedge clk) disable iff (sys_rst)
    read_hit && (|set_vec));
endmodule

// *** design/irq_cause_pkg.sv ***
// constants, field positions and types shared by the interrupt cause block
// assumes a single 125 MHz clock and a 16-bit serial frame from the host
package irq_cause_pkg;
  // ----------------------------------------------------------------
  // serial frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 14;
  localparam int FEEDBACK_BIT = 13;
  localparam int READ_ONLY_BIT = 12;
  localparam logic [1:0] ADDR_IRQ = 2'h1;
  // ----------------------------------------------------------------
  // cause register bits
  // ----------------------------------------------------------------
  localparam int WDT_BIT = 11;
  localparam int OTEMP_BIT = 10;
  localparam int GND_BIT = 9;
  localparam int SPI_BIT = 8;
  localparam int BAT_BIT = 7;
  localparam int SHORT_BIT = 6;
  localparam int CANF_BIT = 5;
  localparam int LINF_BIT = 4;
  localparam int WAKE_BIT = 3;
  localparam int CANW_BIT = 1;
  localparam int LINW_BIT = 0;
  localparam logic [15:0] FLAG_MASK = 16'h0ffb;
  localparam logic [15:0] ENABLE_MASK = 16'h0fff;
  localparam logic [15:0] URGENT_MASK = 16'h0180;
  localparam logic [15:0] CAUSE_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  // ----------------------------------------------------------------
  // synchroniser lanes
  // ----------------------------------------------------------------
  localparam int LVL_OTEMP = 0;
  localparam int LVL_GND = 1;
  localparam int LVL_BAT = 2;
  localparam int LVL_WAKE = 3;
  localparam int LVL_CANF = 4;
  localparam int LVL_LINF = 5;
  localparam int LVL_N = 6;
  localparam logic [LVL_N-1:0] LVL_INIT = 6'h0c;
  localparam int SPI_SCK = 0;
  localparam int SPI_CSN = 1;
  localparam int SPI_MOSI = 2;
  localparam logic [2:0] SPI_INIT = 3'h2;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int IRQ_HIGH_NS = 2000;
  localparam int HOLD_W = 8;
  localparam logic [HOLD_W-1:0] IRQ_HIGH_CYCLES =
    HOLD_W'((IRQ_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  typedef enum logic [2:0] {
    MODE_STARTUP = 3'h0,
    MODE_RESTART = 3'h1,
    MODE_NORMAL = 3'h2,
    MODE_STANDBY = 3'h3,
    MODE_SLEEP = 3'h4,
    MODE_FLASH = 3'h5,
    MODE_FAILSAFE = 3'h6
  } mode_t;
endpackage

// *** design/spi_frame_if.sv ***
// frame hand-off between the serial shifter and the cause register core
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface spi_frame_if;
  logic start;
  logic done;
  logic ok;
  logic [15:0] rx;
  logic [15:0] sent;
  logic [15:0] tx;
  logic miso;
  logic miso_oe;
  modport link (output start, done, ok, rx, sent, miso, miso_oe, input tx);
  modport core (input start, done, ok, rx, sent, miso, miso_oe, output tx);
endinterface

// *** design/sync_edge.sv ***
// two-flop synchroniser with edge detection, one lane per bit
// assumes inputs are asynchronous to clk and slow against it
`timescale 1ns/100ps
module sync_edge #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta;
  logic [W-1:0] prev;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      // meta feeds only level, never any gate
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          meta[i] <= INIT[i];
          level[i] <= INIT[i];
          prev[i] <= INIT[i];
        end else begin
          meta[i] <= async_in[i];
          level[i] <= meta[i];
          prev[i] <= level[i];
        end
      end
      assign rise[i] = level[i] & ~prev[i];
      assign fall[i] = ~level[i] & prev[i];
    end
  endgenerate
endmodule

// *** design/spi_frame.sv ***
// serial slave shifter: mode 0, msb first, 16-bit frames framed by chip select
// assumes sck slower than a quarter of clk; first answer bit settles 3 clocks after csn falls
`timescale 1ns/100ps
module spi_frame
  import irq_cause_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic spi_sck,
  input wire logic spi_csn,
  input wire logic spi_mosi,
  spi_frame_if.link fr
);
  logic [2:0] lvl;
  logic [2:0] rs;
  logic [2:0] fl;
  logic [CNT_W-1:0] bit_cnt;
  logic [15:0] rx_sh;
  logic [15:0] tx_sh;

  sync_edge #(.W(3), .INIT(SPI_INIT)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({spi_mosi, spi_csn, spi_sck}),
    .level(lvl),
    .rise(rs),
    .fall(fl)
  );

  // ----------------------------------------------------------------
  // receive side and clock count
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bit_cnt <= '0;
      rx_sh <= '0;
    end else if (fl[SPI_CSN]) begin
      bit_cnt <= '0;
    end else if (!lvl[SPI_CSN] && rs[SPI_SCK]) begin
      rx_sh <= {rx_sh[14:0], lvl[SPI_MOSI]};
      // saturate so long frames never wrap back to a legal count
      if (bit_cnt != '1) begin
        bit_cnt <= bit_cnt + CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit side; the loaded word is kept to know what was reported
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_sh <= '0;
      fr.sent <= '0;
      fr.miso <= 1'b0;
    end else if (fl[SPI_CSN]) begin
      tx_sh <= fr.tx;
      fr.sent <= fr.tx;
      fr.miso <= fr.tx[FRAME_BITS-1];
    end else if (!lvl[SPI_CSN] && fl[SPI_SCK]) begin
      tx_sh <= {tx_sh[14:0], 1'b0};
      fr.miso <= tx_sh[FRAME_BITS-2];
    end
  end

  // ----------------------------------------------------------------
  // frame boundaries
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fr.start <= 1'b0;
      fr.done <= 1'b0;
      fr.ok <= 1'b0;
      fr.rx <= '0;
      fr.miso_oe <= 1'b0;
    end else begin
      fr.start <= fl[SPI_CSN];
      fr.done <= rs[SPI_CSN];
      fr.ok <= rs[SPI_CSN] && (bit_cnt == CNT_W'(FRAME_BITS));
      if (rs[SPI_CSN]) begin
        fr.rx <= rx_sh;
      end
      fr.miso_oe <= !lvl[SPI_CSN];
    end
  end
endmodule

// *** dv/spi_host_model.sv ***
// host-side serial master that frames commands for the cause register
// assumes mode 0 framing; edges are paced by the block clock, changed on its falling edge
`timescale 1ns/100ps
module spi_host_model
  import irq_cause_pkg::*;
(
  input wire logic clk,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  output logic spi_sck,
  output logic spi_csn,
  output logic spi_mosi
);
  // ----------------------------------------------------------------
  // frame engine
  // ----------------------------------------------------------------
  initial begin
    spi_sck = 1'b0;
    spi_csn = 1'b1;
    spi_mosi = 1'b1;
  end
  // half periods of 5 clocks keep sck under a quarter of clk; an undriven answer reads unknown
  task automatic xfer(input logic [15:0] cmd, input int nbits, output logic [15:0] ans);
    int i;
    ans = 16'h0000;
    @(negedge clk);
    spi_csn = 1'b0;
    spi_mosi = cmd[15];
    repeat (6) @(negedge clk);
    for (i = 0; i < nbits; i++) begin
      spi_sck = 1'b1;
      ans = {ans[14:0], spi_miso_oe ? spi_miso : 1'bx};
      repeat (5) @(negedge clk);
      spi_sck = 1'b0;
      spi_mosi = (i < 15) ? cmd[14 - i] : ~spi_mosi;
      repeat (5) @(negedge clk);
    end
    spi_csn = 1'b1;
    // released data line shows no stale bit
    spi_mosi = ~spi_mosi;
    repeat (10) @(negedge clk);
  endtask
  task automatic read_causes(output logic [15:0] ans);
    xfer({ADDR_IRQ, 2'b11, 12'h000}, FRAME_BITS, ans);
  endtask
  task automatic write_enable(input logic [11:0] data);
    logic [15:0] ans;
    xfer({ADDR_IRQ, 2'b00, data & 12'hffb}, FRAME_BITS, ans);
  endtask
endmodule

// *** dv/test_irq_cause.sv ***
// self-checking bench for the interrupt cause block driven by the host model
// assumes events and mode are driven on the falling clk edge, away from sampling
`timescale 1ns/100ps
module test_irq_cause;
  import irq_cause_pkg::*;
  logic clk, sys_rst, spi_sck, spi_csn, spi_mosi, spi_miso, spi_miso_oe;
  mode_t mode;
  logic wdt_overflow, wdt_period_tick, reset_event, overtemp_warn_in, ground_shift_in;
  logic battery_monitor_in, wake_pin_in, can_fail_status, lin_fail_status;
  logic supply_short_det, can_bus_event, lin_bus_event, irq_out_n, reset_req;
  logic [15:0] irq_enable;
  int fail_count = 0;
  int samples_checked = 0;
  int resets = 0;
  int bit_of [12] = '{OTEMP_BIT, OTEMP_BIT, GND_BIT, GND_BIT, BAT_BIT, SHORT_BIT, CANF_BIT,
                      LINF_BIT, WAKE_BIT, CANW_BIT, LINW_BIT, WDT_BIT};
  irq_cause i_dut (.clk(clk), .sys_rst(sys_rst), .spi_sck(spi_sck), .spi_csn(spi_csn),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .mode(mode),
    .wdt_overflow(wdt_overflow), .wdt_period_tick(wdt_period_tick),
    .reset_event(reset_event), .overtemp_warn_in(overtemp_warn_in),
    .ground_shift_in(ground_shift_in), .battery_monitor_in(battery_monitor_in),
    .wake_pin_in(wake_pin_in), .can_fail_status(can_fail_status),
    .lin_fail_status(lin_fail_status), .supply_short_det(supply_short_det),
    .can_bus_event(can_bus_event), .lin_bus_event(lin_bus_event), .irq_out_n(irq_out_n),
    .reset_req(reset_req), .irq_enable(irq_enable));
  spi_host_model i_host (.clk(clk), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .spi_sck(spi_sck), .spi_csn(spi_csn), .spi_mosi(spi_mosi));
  // ----------------------------------------------------------------
  // clock, reset pulse counter, helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (reset_req === 1'b1) resets <= resets + 1;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // level events toggle and stay; pulses last one cycle; falling pins recover high later
  task automatic fire(input int k);
    case (k)
      0, 1: overtemp_warn_in = ~overtemp_warn_in;
      2, 3: ground_shift_in = ~ground_shift_in;
      4: battery_monitor_in = 1'b0;
      5: supply_short_det = 1'b1;
      6: can_fail_status = ~can_fail_status;
      7: lin_fail_status = ~lin_fail_status;
      8: wake_pin_in = 1'b0;
      9: can_bus_event = 1'b1;
      10: lin_bus_event = 1'b1;
      default: wdt_overflow = 1'b1;
    endcase
    @(negedge clk);
    {supply_short_det, can_bus_event, lin_bus_event, wdt_overflow} = 4'h0;
    repeat (8) @(negedge clk);
    battery_monitor_in = 1'b1;
    wake_pin_in = 1'b1;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    int k;
    int r0;
    logic [15:0] ans;
    sys_rst = 1'b1;
    mode = MODE_STANDBY;
    {wdt_overflow, wdt_period_tick, reset_event, overtemp_warn_in, ground_shift_in} = 5'h00;
    {can_fail_status, lin_fail_status, supply_short_det, can_bus_event, lin_bus_event} = 5'h00;
    battery_monitor_in = 1'b1;
    wake_pin_in = 1'b1;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    repeat (8) @(negedge clk);
    check(16'(irq_out_n), 16'h0001);
    i_host.read_causes(ans);
    check(ans, CAUSE_RESET);
    i_host.write_enable(12'hfff);
    check(irq_enable, 16'h0ffb);
    i_host.read_causes(ans);
    check(irq_enable, 16'h0ffb);
    $display("test enable write done");
    for (k = 0; k < 12; k++) begin
      repeat (260) @(negedge clk);
      fire(k);
      check(16'(irq_out_n), 16'h0000);
      i_host.read_causes(ans);
      check(ans, 16'h0001 << bit_of[k]);
      check(16'(irq_out_n), 16'h0001);
      i_host.read_causes(ans);
      check(ans, 16'h0000);
    end
    $display("test event flags done");
    i_host.write_enable(12'hbf8);
    repeat (260) @(negedge clk);
    r0 = resets;
    fire(0);
    fire(9);
    fire(10);
    check(16'(irq_out_n), 16'h0001);
    check(16'(resets - r0), 16'h0002);
    i_host.read_causes(ans);
    check(ans, 16'h0000);
    i_host.write_enable(12'hfff);
    $display("test disabled causes done");
    for (k = 15; k < 18; k += 2) begin
      i_host.xfer({ADDR_IRQ, 2'b00, 12'h000}, k, ans);
      check(irq_enable, 16'h0ffb);
      repeat (260) @(negedge clk);
      check(16'(irq_out_n), 16'h0000);
      i_host.read_causes(ans);
      check(ans, 16'h0100);
    end
    for (k = 0; k < 2; k++) begin
      mode = k ? MODE_RESTART : MODE_STARTUP;
      r0 = resets;
      i_host.xfer({ADDR_IRQ, 2'b00, 12'h000}, 15, ans);
      check(16'(resets - r0), 16'h0001);
      check(irq_enable, 16'h0ffb);
      i_host.read_causes(ans);
      check(ans, 16'h0000);
    end
    mode = MODE_STANDBY;
    $display("test clock count done");
    fork
      i_host.read_causes(ans);
      begin
        // the event lands mid-frame, after the answer copy was taken
        repeat (40) @(negedge clk);
        fire(9);
      end
    join
    check(ans, 16'h0000);
    i_host.read_causes(ans);
    check(ans, 16'h0002);
    fire(5);
    repeat (150) @(negedge clk);
    check(16'(irq_out_n), 16'h0001);
    repeat (110) @(negedge clk);
    check(16'(irq_out_n), 16'h0000);
    $display("test read overlap done");
    mode = MODE_NORMAL;
    i_host.read_causes(ans);
    repeat (260) @(negedge clk);
    fire(5);
    repeat (20) @(negedge clk);
    check(16'(irq_out_n), 16'h0001);
    wdt_period_tick = 1'b1;
    @(negedge clk);
    wdt_period_tick = 1'b0;
    repeat (4) @(negedge clk);
    check(16'(irq_out_n), 16'h0000);
    i_host.read_causes(ans);
    check(ans, 16'h0040);
    mode = MODE_FLASH;
    repeat (260) @(negedge clk);
    fire(4);
    check(16'(irq_out_n), 16'h0000);
    i_host.read_causes(ans);
    check(ans, 16'h0080);
    repeat (260) @(negedge clk);
    fire(5);
    check(16'(irq_out_n), 16'h0001);
    $display("test pacing done");
    fire(9);
    reset_event = 1'b1;
    @(negedge clk);
    reset_event = 1'b0;
    i_host.read_causes(ans);
    check(ans, 16'h0000);
    fire(10);
    sys_rst = 1'b1;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    repeat (8) @(negedge clk);
    i_host.read_causes(ans);
    check(ans, 16'h0000);
    $display("test reset clear done");
    conclude();
  end
  initial begin
    #400000;
    fail_count++;
    $display("watchdog expired");
    conclude();
  end
endmodule
